//--- sssc_top.sv
// SPI slave serial controller: link sampling, serializer, FIFOs, flags, events.
// Assumes DMA and software share the FIFO ports and all strobes are on clock.
//
// Function
// R01: Slave only when mode is 2, master bit 0
// R02: Master clock drives shifting, at most 5 Mbps
// R03: Polarity, phase and bit order set format
// R04: Drive MISO and sample MOSI while selected
// R05: Select falling edge resets both shift registers
// R06: Four-entry FIFOs, data port pushes and pops
// R07: DMA uses the same FIFO paths
// R08: Received characters stored, receive valid set
// R09: Full receive FIFO drops character, flags overrun
// R10: DMA overrun after drain, cleared by reset/reload
// R11: Each received character shifts one transmit out
// R12: Empty transmit FIFO: underrun, send last/busy
// R13: Write into idle transmitter clears idle flag
// R14: Free clears on full, sets on shift-out
// R15: Idle sets when FIFO and serializer empty
// R16: Pad byte before new data while selected
// R17: First select rise saves active receive count
// R18: Three-bit record of save, buffer, extra edge
// R19: Idle, free, valid events by edge or level
// R20: DMA completion, overrun, underrun raise events
// R21: CPU request needs event and top enable
// R22: Select, MOSI, SCLK in; MISO out
// R23: Link signals synchronised before status update
`timescale 1ns/1ps
`default_nettype none
module sssc_top
  import sssc_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int CNT_W = RX_COUNT_W
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [1:0] serial_mode_select,
  input wire logic master_select_bit,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic bit_order_bit,
  input wire logic repeat_select_bit,
  input wire logic sclk_in,
  input wire logic slave_select_n,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic tx_wr_valid,
  input wire logic [7:0] tx_wr_data,
  output logic tx_wr_ready,
  input wire logic rx_rd_pop,
  output logic [7:0] rx_rd_data,
  output logic tx_idle_flag,
  output logic tx_free_flag,
  output logic rx_valid_flag,
  output logic rx_overrun_flag,
  input wire logic rx_overrun_clear,
  output logic rx_overrun_irq,
  output logic tx_underrun_irq,
  input wire logic rx_dma_active,
  input wire logic rx_dma_load,
  input wire logic [1:0] dma_reset_bits,
  output logic rx_dma_error,
  input wire logic [1:0] tx_buffer_active_bits,
  input wire logic [1:0] rx_buffer_active_bits,
  input wire logic [CNT_W-1:0] rx_dma_count_a,
  input wire logic [CNT_W-1:0] rx_dma_count_b,
  output logic [CNT_W-1:0] saved_rx_count_reg,
  output logic [2:0] select_edge_record_field,
  input wire logic [2:0] irq_mode_reg,
  input wire logic [IRQ_N-1:0] irq_enable_reg,
  input wire logic top_irq_set_reg,
  input wire logic [IRQ_N-1:0] irq_flag_clear,
  output logic [IRQ_N-1:0] irq_flag_reg,
  output logic cpu_irq
);

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  logic [2:0] pin_s;
  logic sclk_s, ssn_s, mosi_s;
  logic sclk_prev_q, ssn_prev_q;
  logic active, sel, sel_fall, sel_rise, lead, trail;
  logic sample_edge, shift_edge, byte_done, load_char;

  // Select resets high so no false edge appears after reset
  sssc_sync #(.WIDTH(3), .RESET_VALUE(3'h2)) u_sync ( // [R23]
    .clock(clock),
    .srst(srst),
    .async_in({mosi_in, slave_select_n, sclk_in}),
    .sync_out(pin_s)
  );
  assign sclk_s = pin_s[0];
  assign ssn_s = pin_s[1];
  assign mosi_s = pin_s[2];

  always_ff @(posedge clock) begin
    if (srst) begin
      sclk_prev_q <= 1'b0;
      ssn_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      ssn_prev_q <= ssn_s;
    end
  end

  assign active = (serial_mode_select == MODE_SPI) && (master_select_bit == SEL_SLAVE); // [R01]
  assign sel = active && !ssn_s; // [R04]
  assign sel_fall = active && ssn_prev_q && !ssn_s;
  assign sel_rise = active && !ssn_prev_q && ssn_s;
  // Edges of the master's clock, with polarity folded out; the rate limit
  // keeps each half period several system cycles long
  assign lead = sel && (sclk_s ^ clock_polarity_bit) && !(sclk_prev_q ^ clock_polarity_bit); // [R02] [R03]
  assign trail = sel && !(sclk_s ^ clock_polarity_bit) && (sclk_prev_q ^ clock_polarity_bit);
  assign sample_edge = clock_phase_bit ? trail : lead; // [R03]
  assign shift_edge = clock_phase_bit ? lead : trail;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  logic tx_ready_w, tx_valid_w, rx_ready_w, rx_valid_w;
  logic [7:0] tx_head_w;
  logic tx_push, tx_pop, rx_push, rx_ovf;
  logic [7:0] rx_char;
  logic [2:0] bitcnt_q;
  logic [7:0] rx_sr_q;

  assign tx_push = tx_wr_valid && tx_ready_w;
  assign tx_wr_ready = tx_ready_w;
  assign rx_valid_flag = rx_valid_w; // [R08]

  sssc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_tx_fifo ( // [R06] [R07]
    .clock(clock),
    .srst(srst),
    .in_valid(tx_wr_valid),
    .in_data(tx_wr_data),
    .in_ready(tx_ready_w),
    .out_pop(tx_pop),
    .out_valid(tx_valid_w),
    .out_data(tx_head_w)
  );

  sssc_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_rx_fifo ( // [R06] [R07] [R08]
    .clock(clock),
    .srst(srst),
    .in_valid(rx_push),
    .in_data(rx_char),
    .in_ready(rx_ready_w),
    .out_pop(rx_rd_pop),
    .out_valid(rx_valid_w),
    .out_data(rx_rd_data)
  );

  // ----------------------------------------------------------------
  // Receive shifter
  // ----------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b,
                                          input logic lsb_first);
    shift_in = lsb_first ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  function automatic logic pick(input logic [7:0] c, input logic [2:0] idx,
                                input logic lsb_first);
    pick = lsb_first ? c[idx] : c[BIT_LAST - idx];
  endfunction

  assign byte_done = sample_edge && (bitcnt_q == BIT_LAST);
  assign rx_char = shift_in(rx_sr_q, mosi_s, bit_order_bit);
  assign rx_push = byte_done && rx_ready_w; // [R08]
  assign rx_ovf = byte_done && !rx_ready_w; // [R09]

  always_ff @(posedge clock) begin
    if (srst) begin
      bitcnt_q <= BIT_FIRST;
      rx_sr_q <= CHAR_RESET;
    end else if (sel_fall) begin
      bitcnt_q <= BIT_FIRST; // [R05]
      rx_sr_q <= CHAR_RESET;
    end else if (sample_edge) begin
      bitcnt_q <= bitcnt_q + 1'b1;
      rx_sr_q <= rx_char; // [R04]
    end
  end

  // ----------------------------------------------------------------
  // Transmit serializer
  // ----------------------------------------------------------------
  logic [7:0] tx_char_q, last_char_q, pad_val, next_char;
  logic ser_busy_q, pad_armed_q, pad_pend_q, underrun;

  // A character still held from the last frame is restarted, not replaced
  assign load_char = byte_done || (sel_fall && !ser_busy_q); // [R05] [R11]
  // Polarity of repeat_select_bit: high repeats the last character
  assign pad_val = repeat_select_bit ? last_char_q : BUSY_TOKEN; // [R12] [R16]
  assign tx_pop = load_char && tx_valid_w && !pad_pend_q;
  assign underrun = load_char && !tx_valid_w && !pad_pend_q; // [R12]
  assign next_char = tx_pop ? tx_head_w : pad_val;

  always_ff @(posedge clock) begin
    if (srst) begin
      tx_char_q <= CHAR_RESET;
      last_char_q <= CHAR_RESET;
    end else if (load_char) begin
      tx_char_q <= next_char; // [R05] [R11]
      last_char_q <= next_char;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ser_busy_q <= 1'b0;
    end else if (load_char) begin
      // Held across a deselect until shifted out, so no write is lost
      ser_busy_q <= tx_pop;
    end
  end

  // MISO holds its bit between edges; first bit is ready at load for phase 0
  always_ff @(posedge clock) begin
    if (srst) begin
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= sel; // [R04] [R22]
      if (load_char) begin
        miso_out <= pick(next_char, BIT_FIRST, bit_order_bit); // [R03]
      end else if (sel_fall) begin
        miso_out <= pick(tx_char_q, BIT_FIRST, bit_order_bit); // [R05]
      end else if (shift_edge) begin
        miso_out <= pick(tx_char_q, bitcnt_q, bit_order_bit);
      end
    end
  end

  // Padding gives the serializer time to fetch fresh data mid-frame
  always_ff @(posedge clock) begin
    if (srst) begin
      pad_armed_q <= 1'b0;
      pad_pend_q <= 1'b0;
    end else begin
      pad_armed_q <= sel && (pad_armed_q || rx_valid_w); // [R16]
      if (pad_armed_q && sel && tx_push && !tx_valid_w) begin
        pad_pend_q <= 1'b1; // [R16]
      end else if (load_char || !sel) begin
        pad_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      tx_idle_flag <= 1'b1;
      tx_free_flag <= 1'b1;
    end else begin
      tx_idle_flag <= !tx_valid_w && !ser_busy_q && !tx_push && !pad_pend_q; // [R13] [R15]
      if (!tx_ready_w) begin
        tx_free_flag <= 1'b0; // [R14]
      end else if (byte_done) begin
        tx_free_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_overrun_flag <= 1'b0;
      rx_overrun_irq <= 1'b0;
      tx_underrun_irq <= 1'b0;
    end else begin
      rx_overrun_flag <= rx_ovf || (rx_overrun_flag && !rx_overrun_clear); // [R09]
      rx_overrun_irq <= rx_ovf;
      tx_underrun_irq <= underrun; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // Receive DMA: error reporting and count save
  // ----------------------------------------------------------------
  logic ovf_pend_q, saved_once_q, err_clr;

  assign err_clr = dma_reset_bits[DMA_RST_RX] || rx_dma_load;

  // The error waits until the characters ahead of it are drained
  always_ff @(posedge clock) begin
    if (srst) begin
      ovf_pend_q <= 1'b0;
      rx_dma_error <= 1'b0;
    end else begin
      if (rx_ovf && rx_dma_active) begin
        ovf_pend_q <= 1'b1;
      end else if (ovf_pend_q && !rx_valid_w) begin
        ovf_pend_q <= 1'b0;
      end
      if (ovf_pend_q && !rx_valid_w) begin
        rx_dma_error <= 1'b1; // [R10]
      end else if (err_clr) begin
        rx_dma_error <= 1'b0; // [R10]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      saved_once_q <= 1'b0;
      saved_rx_count_reg <= COUNT_RESET;
      select_edge_record_field <= SEL_REC_RESET;
    end else if (sel_rise && rx_dma_active) begin
      if (!saved_once_q) begin
        saved_once_q <= 1'b1;
        saved_rx_count_reg <= rx_buffer_active_bits[BUF_A] ? rx_dma_count_a
                                                            : rx_dma_count_b; // [R17]
        select_edge_record_field[SEL_SAVED] <= 1'b1; // [R18]
        select_edge_record_field[SEL_FROM_B] <= !rx_buffer_active_bits[BUF_A];
      end else begin
        select_edge_record_field[SEL_EXTRA] <= 1'b1; // [R17] [R18]
      end
    end else if (rx_dma_load) begin
      saved_once_q <= 1'b0;
      select_edge_record_field <= SEL_REC_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Second-level events and CPU request
  // ----------------------------------------------------------------
  logic [2:0] lvl_prev_q;
  logic [1:0] txb_prev_q, rxb_prev_q;
  logic [2:0] lvl;
  logic [IRQ_N-1:0] ev;

  assign lvl = {rx_valid_flag, tx_free_flag, tx_idle_flag};

  always_ff @(posedge clock) begin
    if (srst) begin
      lvl_prev_q <= 3'h0;
      txb_prev_q <= 2'h0;
      rxb_prev_q <= 2'h0;
    end else begin
      lvl_prev_q <= lvl;
      txb_prev_q <= tx_buffer_active_bits;
      rxb_prev_q <= rx_buffer_active_bits;
    end
  end

  always_comb begin
    ev = IRQ_RESET;
    for (int i = 0; i < 3; i++) begin
      ev[IRQ_TXIDLE + i] = lvl[i] && (irq_mode_reg[i] || !lvl_prev_q[i]); // [R19]
    end
    ev[IRQ_TXBUF_A] = txb_prev_q[BUF_A] && !tx_buffer_active_bits[BUF_A]; // [R20]
    ev[IRQ_TXBUF_B] = txb_prev_q[BUF_B] && !tx_buffer_active_bits[BUF_B];
    ev[IRQ_RXBUF_A] = rxb_prev_q[BUF_A] && !rx_buffer_active_bits[BUF_A];
    ev[IRQ_RXBUF_B] = rxb_prev_q[BUF_B] && !rx_buffer_active_bits[BUF_B];
    ev[IRQ_RXOVF] = rx_overrun_irq;
    ev[IRQ_TXUND] = tx_underrun_irq;
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_flag_reg <= IRQ_RESET;
      cpu_irq <= 1'b0;
    end else begin
      irq_flag_reg <= ev | (irq_flag_reg & ~irq_flag_clear); // [R20]
      cpu_irq <= top_irq_set_reg && |(irq_flag_reg & irq_enable_reg); // [R21]
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_sel_fall;
    active && ssn_prev_q && !ssn_s;
  endsequence

  sequence s_full_char;
    sample_edge && (bitcnt_q == BIT_LAST);
  endsequence

  AST_NO_DRIVE_UNSELECTED: assert property (!sel |=> !miso_oe) // [R04]
    else $error("MISO driven while not selected");
  AST_INACTIVE_MODE: assert property (!active |=> !miso_oe) // [R01]
    else $error("MISO driven outside slave mode");
  AST_SEL_FALL_RESETS: assert property (s_sel_fall |=> bitcnt_q == BIT_FIRST
                                        && rx_sr_q == CHAR_RESET) // [R05]
    else $error("Shift registers not reset on select fall");
  AST_OVERRUN: assert property (s_full_char ##0 !rx_ready_w |=> rx_overrun_flag
                                && rx_overrun_irq) // [R09]
    else $error("Overrun not flagged");
  AST_STORE: assert property (s_full_char ##0 rx_ready_w |=> ##1 rx_valid_flag) // [R08]
    else $error("Received character not stored");
  AST_UNDERRUN: assert property (underrun |=> tx_underrun_irq && last_char_q == $past(pad_val)) // [R12]
    else $error("Underrun not handled");
  AST_FREE_CLEAR: assert property (!tx_ready_w |=> !tx_free_flag) // [R14]
    else $error("Free flag not cleared on full");
  AST_IDLE_CLEAR: assert property (tx_push |=> !tx_idle_flag) // [R13]
    else $error("Idle flag not cleared by write");
  AST_SAVE_COUNT: assert property (sel_rise && rx_dma_active && !saved_once_q
                                   && rx_buffer_active_bits[BUF_A]
                                   |=> saved_rx_count_reg == $past(rx_dma_count_a)) // [R17]
    else $error("Receive count not saved");
  AST_RXVAL_EDGE: assert property ($rose(rx_valid_flag) |=> irq_flag_reg[IRQ_RXVAL]) // [R19]
    else $error("Receive valid event missed");
  AST_CPU_GATE: assert property (cpu_irq |-> $past(top_irq_set_reg)) // [R21]
    else $error("CPU request without top enable");

endmodule
`default_nettype wire

//--- sssc_pkg.sv
// Shared constants for the SPI slave serial controller.
// Assumes a single 50 MHz system clock; link pins are sampled, not clocked.
package sssc_pkg;

  // ----------------------------------------------------------------
  // Clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int LINK_MAX_MBPS = 5;
  // Least system cycles per serial bit the sampling logic can follow
  localparam int LINK_MIN_BIT_CYC = (CLK_MHZ + LINK_MAX_MBPS - 1) / LINK_MAX_MBPS;

  // ----------------------------------------------------------------
  // Mode selection and character format
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SPI = 2'h2;
  localparam logic SEL_SLAVE = 1'h0;
  localparam int DATA_W = 8;
  localparam logic [7:0] BUSY_TOKEN = 8'hFF;
  localparam logic [7:0] CHAR_RESET = 8'h00;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int FIFO_DEPTH = 4;
  localparam int RX_COUNT_W = 16;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int DMA_RST_TX = 0;
  localparam int DMA_RST_RX = 1;
  localparam int BUF_A = 0;
  localparam int BUF_B = 1;
  // select_edge_record_field
  localparam int SEL_SAVED = 0;
  localparam int SEL_FROM_B = 1;
  localparam int SEL_EXTRA = 2;
  localparam logic [2:0] SEL_REC_RESET = 3'h0;
  // irq_mode_reg: 1 = level, 0 = rising transition
  localparam int MODE_TXIDLE = 0;
  localparam int MODE_TXFREE = 1;
  localparam int MODE_RXVAL = 2;
  // irq_flag_reg / irq_enable_reg
  localparam int IRQ_N = 9;
  localparam int IRQ_TXIDLE = 0;
  localparam int IRQ_TXFREE = 1;
  localparam int IRQ_RXVAL = 2;
  localparam int IRQ_TXBUF_A = 3;
  localparam int IRQ_TXBUF_B = 4;
  localparam int IRQ_RXBUF_A = 5;
  localparam int IRQ_RXBUF_B = 6;
  localparam int IRQ_RXOVF = 7;
  localparam int IRQ_TXUND = 8;
  localparam logic [8:0] IRQ_RESET = 9'h000;

endpackage

//--- sssc_sync.sv
// Two-stage synchroniser for pins arriving from the SPI master.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/1ps
`default_nettype none
module sssc_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_q <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- sssc_fifo.sv
// Small character FIFO with registered head data.
// Assumes the caller never pops when out_valid is low.
`timescale 1ns/1ps
`default_nettype none
module sssc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  input wire logic out_pop,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q, rd_next;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    nxt = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = in_valid && in_ready;
  assign pop = out_pop && out_valid;
  assign rd_next = pop ? nxt(rd_q) : rd_q;

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      if (push) begin
        wr_q <= nxt(wr_q);
      end
      rd_q <= rd_next;
      cnt_q <= cnt_d;
      in_ready <= (cnt_d != CW'(DEPTH));
      out_valid <= (cnt_d != '0);
      // Bypass when the new head is the slot being written this cycle
      out_data <= (push && wr_q == rd_next) ? in_data : mem[rd_next];
    end
  end

endmodule
`default_nettype wire

//--- sssc_spi_master.sv
// SPI master model: drives select, serial clock and MOSI toward the slave.
// Assumes a 160 ns link period; the caller waits for each call to return.
`timescale 1ns/1ps
`default_nettype none
module sssc_spi_master (
  output logic sclk,
  output logic ssn,
  output logic mosi,
  input wire logic miso
);
  localparam time HALF = 80;
  initial begin
    sclk = 1'b0;
    ssn = 1'b1;
    mosi = 1'b0;
  end
  // ----------------------------------------------------------------
  // One character per frame
  // ----------------------------------------------------------------
  // Clock idles at cpol and stands still outside frames
  task automatic xfer(input logic cpol, cpha, lsb, input logic [7:0] tx,
                      output logic [7:0] rx);
    int b;
    sclk = cpol;
    #(2*HALF) ssn = 1'b0;
    #(2*HALF);
    for (int i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      if (!cpha) mosi = tx[b];
      #HALF sclk = ~cpol;
      // Data has stood about a quarter of a half period; take it on the edge itself
      if (!cpha) rx[b] = miso;
      if (cpha) mosi = tx[b];
      #HALF sclk = cpol;
      if (cpha) rx[b] = miso;
    end
    #HALF ssn = 1'b1;
    // Released data line must not look like held data
    mosi = ~mosi;
    #(4*HALF);
  endtask
endmodule
`default_nettype wire

//--- test_spi_slave_serial_controller.sv
// Self-checking bench for the SPI slave serial controller.
// Assumes sssc_pkg, the design files and the master model sssc_spi_master.
`timescale 1ns/1ps
`default_nettype none
module test_spi_slave_serial_controller;
  import sssc_pkg::*;
  logic clock, srst, msel, pol, pha, ord, rpt, sclk, ssn, mosi, miso, oe, seen_oe;
  logic wv, wr, pop, idle, free, rxv, ovf, ovf_clr, ovf_irq, und_irq;
  logic dma_on, dma_ld, dma_err, top_en, cpu;
  logic [1:0] mode, dma_rst, txact, rxact;
  logic [7:0] wd, rd, got;
  logic [15:0] cnt_a, cnt_b, saved;
  logic [2:0] rec, imode;
  logic [8:0] ien, iclr, iflag;
  wire miso_pin;
  int errors, cmp_count;

  assign miso_pin = oe ? miso : 1'bz;
  sssc_top dut (
    .clock(clock), .srst(srst), .serial_mode_select(mode), .master_select_bit(msel),
    .clock_polarity_bit(pol), .clock_phase_bit(pha), .bit_order_bit(ord),
    .repeat_select_bit(rpt), .sclk_in(sclk), .slave_select_n(ssn), .mosi_in(mosi),
    .miso_out(miso), .miso_oe(oe), .tx_wr_valid(wv), .tx_wr_data(wd), .tx_wr_ready(wr),
    .rx_rd_pop(pop), .rx_rd_data(rd), .tx_idle_flag(idle), .tx_free_flag(free),
    .rx_valid_flag(rxv), .rx_overrun_flag(ovf), .rx_overrun_clear(ovf_clr),
    .rx_overrun_irq(ovf_irq), .tx_underrun_irq(und_irq), .rx_dma_active(dma_on),
    .rx_dma_load(dma_ld), .dma_reset_bits(dma_rst), .rx_dma_error(dma_err),
    .tx_buffer_active_bits(txact), .rx_buffer_active_bits(rxact),
    .rx_dma_count_a(cnt_a), .rx_dma_count_b(cnt_b), .saved_rx_count_reg(saved),
    .select_edge_record_field(rec), .irq_mode_reg(imode), .irq_enable_reg(ien),
    .top_irq_set_reg(top_en), .irq_flag_clear(iclr), .irq_flag_reg(iflag), .cpu_irq(cpu));
  sssc_spi_master m (.sclk(sclk), .ssn(ssn), .mosi(mosi), .miso(miso_pin));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic push(input logic [7:0] d);
    wv = 1'b1;
    wd = d;
    tick(1);
    wv = 1'b0;
    tick(1);
  endtask
  task automatic rcv(input logic [7:0] e);
    check(rxv, 1'b1);
    check(rd, e);
    pop = 1'b1;
    tick(1);
    pop = 1'b0;
    tick(2);
  endtask
  // One frame; MISO enable is sampled mid-frame
  task automatic sx(input logic [7:0] d, input logic en);
    fork
      m.xfer(pol, pha, ord, d, got);
      #400 seen_oe = oe;
    join
    check(seen_oe, en);
    tick(6);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_formats();
    for (int f = 0; f < 8; f++) begin
      {pol, pha, ord} = 3'(f);
      push({3'(f), 5'h0B});
      check(idle, 1'b0);
      sx({5'h13, 3'(f)}, 1'b1);
      check(got, {3'(f), 5'h0B});
      check(idle, 1'b1);
      rcv({5'h13, 3'(f)});
    end
  endtask
  task automatic t_underrun();
    iclr = '1;
    tick(1);
    iclr = '0;
    sx(8'h5C, 1'b1);
    check(got, 8'hEB);
    check(iflag[IRQ_TXUND], 1'b1);
    rpt = 1'b0;
    sx(8'h5D, 1'b1);
    check(got, BUSY_TOKEN);
    rcv(8'h5C);
    rcv(8'h5D);
  endtask
  // Fifth push is refused; five frames without reads overrun the receiver
  task automatic t_full();
    rpt = 1'b1;
    dma_on = 1'b1;
    for (int i = 0; i < 5; i++) push(8'h11 * 8'(i + 1));
    check(wr, 1'b0);
    check(free, 1'b0);
    for (int i = 0; i < 5; i++) begin
      sx(8'hA0 + 8'(i), 1'b1);
      check(got, 8'h11 * 8'(i < 4 ? i + 1 : 4));
      check(free, 1'b1);
    end
    check(ovf, 1'b1);
    check(iflag[IRQ_RXOVF], 1'b1);
    check(dma_err, 1'b0);
    for (int i = 0; i < 4; i++) rcv(8'hA0 + 8'(i));
    check(rxv, 1'b0);
    check(dma_err, 1'b1);
    dma_rst = 2'b10;
    tick(1);
    dma_rst = 2'b00;
    dma_on = 1'b0;
    check(dma_err, 1'b0);
    ovf_clr = 1'b1;
    tick(1);
    ovf_clr = 1'b0;
    tick(2);
    check(ovf, 1'b0);
  endtask
  task automatic t_mode();
    mode = 2'h1;
    sx(8'h66, 1'b0);
    mode = MODE_SPI;
    msel = 1'b1;
    sx(8'h67, 1'b0);
    msel = SEL_SLAVE;
    check(rxv, 1'b0);
  endtask
  task automatic t_dma();
    {dma_on, dma_ld, rxact, cnt_a} = {2'b11, 2'b01, 16'h1234};
    tick(1);
    dma_ld = 1'b0;
    sx(8'h70, 1'b1);
    check(saved, 16'h1234);
    check(rec, 3'b001);
    cnt_a = 16'h4321;
    sx(8'h71, 1'b1);
    check(saved, 16'h1234);
    check(rec, 3'b101);
    rxact = 2'b00;
    tick(4);
    check(iflag[IRQ_RXBUF_A], 1'b1);
    rcv(8'h70);
    rcv(8'h71);
  endtask
  task automatic t_irq();
    iclr = '1;
    tick(1);
    iclr = '0;
    sx(8'h7E, 1'b1);
    check(iflag[IRQ_RXVAL], 1'b1);
    ien[IRQ_RXVAL] = 1'b1;
    tick(3);
    check(cpu, 1'b0);
    top_en = 1'b1;
    tick(3);
    check(cpu, 1'b1);
    rcv(8'h7E);
  endtask
  // ----------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    errors = 0;
    cmp_count = 0;
    {srst, rpt} = 2'b11;
    {msel, pol, pha, ord, wv, pop, ovf_clr, dma_on, dma_ld, top_en} = '0;
    {mode, dma_rst, txact, rxact} = {MODE_SPI, 6'h00};
    {wd, cnt_a, cnt_b, imode, ien, iclr} = '0;
    repeat (5) @(posedge clock);
    #1 srst = 1'b0;
    tick(3);
    check({oe, idle, free, wr, rxv}, 5'b01110);
    t_formats();
    t_underrun();
    t_full();
    t_mode();
    t_dma();
    t_irq();
    end_of_test();
  end
  // Whole run needs about 50 us
  initial begin
    #200us;
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
